// [rtl/gpl_port.sv]
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: output mode write drives latch to pin
// R2: input mode write updates latch only
// R3: latch holds until next write
// R4: data latches reset to zero
// R5: output mode read returns latch
// R6: input mode read returns pin level
// R7: output mode rmw works on latch
// R8: input mode rmw works on pin
// R9: bit operations are full byte accesses
// R10: external clock port12 bits read zero
// R11: pull-up only when selected and input
// R12: no pull-up in output or alternate output
// R13: pull-up bits exist only where listed
// R14: pull-up selects reset to zero
// R15: config k makes k low port2 pins digital
// R16: pin config resets all analog
// R17: pin config write inserts wait cycle
// R18: software avoids config write on subclock
// R19: software sets conversion pins to input
// R20: byte and bit writes both accepted
// R21: direction bit 0 output, 1 input
// R22: direction registers reset to all ones
// R23: software never outputs on analog pin
// R24: pins pass two-stage synchroniser
module gpl_port (
  input  wire logic        clk,
  input  wire logic        resetn,
  // cpu memory bus
  input  wire logic        bus_sel,
  input  wire logic        bus_wr,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_bit_mask,
  output logic      [7:0]  bus_rdata,
  output logic             bus_wait,
  // board pins, one byte per port in port-index order
  input  wire logic [55:0] pin_in,
  output logic      [55:0] pin_out,
  output logic      [55:0] pin_oe,
  output logic      [55:0] pin_pullup_en,
  // alternate-function output claim and clock-input mode
  input  wire logic [55:0] alt_out_en,
  input  wire logic [7:0]  p12_ext_clk_mode,
  // converter side: port2 pins handed to analog
  output logic      [7:0]  analog_channel_pins
);

  localparam int NP = gpl_pkg::NPORT;

  typedef struct packed {
    logic [NP-1:0][7:0] data;
    logic [NP-1:0][7:0] dir;
    logic [NP-1:0][7:0] pu;
    logic [3:0]         cfg;
    logic [NP-1:0][7:0] sync1;
    logic [NP-1:0][7:0] sync2;
    logic [7:0]         rdata;
    logic               wait_pend;
    logic [NP-1:0][7:0] pout;
    logic [NP-1:0][7:0] poe;
    logic [NP-1:0][7:0] ppu;
    logic [7:0]         ana;
  } gpl_state_t;

  gpl_state_t s_q;
  gpl_state_t s_d;

  // map a data address to a port index, valid flag in bit 3
  function automatic logic [3:0] gpl_data_idx(input logic [15:0] a);
    unique case (a)
      gpl_pkg::ADDR_PORT0_DATA:  gpl_data_idx = {1'b1, gpl_pkg::IDX_P0};
      gpl_pkg::ADDR_PORT1_DATA:  gpl_data_idx = {1'b1, gpl_pkg::IDX_P1};
      gpl_pkg::ADDR_PORT2_DATA:  gpl_data_idx = {1'b1, gpl_pkg::IDX_P2};
      gpl_pkg::ADDR_PORT3_DATA:  gpl_data_idx = {1'b1, gpl_pkg::IDX_P3};
      gpl_pkg::ADDR_PORT6_DATA:  gpl_data_idx = {1'b1, gpl_pkg::IDX_P6};
      gpl_pkg::ADDR_PORT7_DATA:  gpl_data_idx = {1'b1, gpl_pkg::IDX_P7};
      gpl_pkg::ADDR_PORT12_DATA: gpl_data_idx = {1'b1, gpl_pkg::IDX_P12};
      default:                   gpl_data_idx = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] gpl_dir_idx(input logic [15:0] a);
    unique case (a)
      gpl_pkg::ADDR_DIR0:  gpl_dir_idx = {1'b1, gpl_pkg::IDX_P0};
      gpl_pkg::ADDR_DIR1:  gpl_dir_idx = {1'b1, gpl_pkg::IDX_P1};
      gpl_pkg::ADDR_DIR2:  gpl_dir_idx = {1'b1, gpl_pkg::IDX_P2};
      gpl_pkg::ADDR_DIR3:  gpl_dir_idx = {1'b1, gpl_pkg::IDX_P3};
      gpl_pkg::ADDR_DIR6:  gpl_dir_idx = {1'b1, gpl_pkg::IDX_P6};
      gpl_pkg::ADDR_DIR7:  gpl_dir_idx = {1'b1, gpl_pkg::IDX_P7};
      gpl_pkg::ADDR_DIR12: gpl_dir_idx = {1'b1, gpl_pkg::IDX_P12};
      default:             gpl_dir_idx = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] gpl_pu_idx(input logic [15:0] a);
    unique case (a)
      gpl_pkg::ADDR_PU0:  gpl_pu_idx = {1'b1, gpl_pkg::IDX_P0};
      gpl_pkg::ADDR_PU1:  gpl_pu_idx = {1'b1, gpl_pkg::IDX_P1};
      gpl_pkg::ADDR_PU3:  gpl_pu_idx = {1'b1, gpl_pkg::IDX_P3};
      gpl_pkg::ADDR_PU7:  gpl_pu_idx = {1'b1, gpl_pkg::IDX_P7};
      gpl_pkg::ADDR_PULLUP_SEL_PORT12: gpl_pu_idx = {1'b1, gpl_pkg::IDX_P12};
      default:            gpl_pu_idx = 4'h0;
    endcase
  endfunction

  // byte seen by a port read: latch for outputs, pin for inputs
  function automatic logic [7:0] gpl_port_view(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] pin
  );
    gpl_port_view = (latch & ~dir) | (pin & dir); // [R5] [R6]
  endfunction

  // digital-pin mask of port2 for a config value
  function automatic logic [7:0] gpl_dig_mask(input logic [3:0] k);
    logic [8:0] ones;
    ones = 9'h001 << k;
    gpl_dig_mask = ones[7:0] - 8'h01;
    if (k >= gpl_pkg::CFG_MAX) begin
      gpl_dig_mask = 8'hFF; // prohibited codes act as all digital
    end
  endfunction

  logic [3:0] di;
  logic [3:0] mi;
  logic [3:0] ui;
  logic [7:0] view;
  logic [7:0] merged;
  logic [7:0] dmask;

  // next-state logic for the whole port block
  always_comb begin
    s_d   = s_q;
    di    = gpl_data_idx(bus_addr);
    mi    = gpl_dir_idx(bus_addr);
    ui    = gpl_pu_idx(bus_addr);
    view  = 8'h00;
    merged = 8'h00;
    dmask = gpl_dig_mask(s_q.cfg);

    // pins into two flops before anything reads them
    s_d.sync1 = pin_in; // [R24]
    s_d.sync2 = s_q.sync1; // [R24]

    if (di[3]) begin
      view = gpl_port_view(s_q.data[di[2:0]], s_q.dir[di[2:0]],
                           s_q.sync2[di[2:0]]);
      if (di[2:0] == gpl_pkg::IDX_P12) begin
        view = view & ~(p12_ext_clk_mode & gpl_pkg::P12_CLK_MASK); // [R10]
      end
      view = view & gpl_pkg::PIN_MASK[di[2:0]];
    end

    // bit write merges into the read view of the whole byte,
    // so other input bits pick up their pin level
    merged = (view & ~bus_bit_mask) | (bus_wdata & bus_bit_mask); // [R9]

    s_d.rdata = 8'h00;
    if (bus_sel && !bus_wr) begin
      if (di[3]) begin
        s_d.rdata = view; // [R5] [R6]
      end else if (mi[3]) begin
        s_d.rdata = s_q.dir[mi[2:0]];
      end else if (ui[3]) begin
        s_d.rdata = s_q.pu[ui[2:0]] & gpl_pkg::PU_MASK[ui[2:0]]; // [R13]
      end else if (bus_addr == gpl_pkg::ADDR_PIN_CFG) begin
        s_d.rdata = {4'h0, s_q.cfg};
      end
    end

    // writes: latch updated in either mode, holds otherwise
    s_d.wait_pend = 1'b0;
    if (bus_sel && bus_wr) begin // [R20]
      if (di[3]) begin
        s_d.data[di[2:0]] = merged & gpl_pkg::PIN_MASK[di[2:0]]; // [R1] [R2] [R7] [R8]
      end else if (mi[3]) begin
        s_d.dir[mi[2:0]] = (s_q.dir[mi[2:0]] & ~bus_bit_mask)
                         | (bus_wdata & bus_bit_mask)
                         | ~gpl_pkg::PIN_MASK[mi[2:0]];
      end else if (ui[3]) begin
        s_d.pu[ui[2:0]] = ((s_q.pu[ui[2:0]] & ~bus_bit_mask)
                        | (bus_wdata & bus_bit_mask))
                        & gpl_pkg::PU_MASK[ui[2:0]]; // [R13]
      end else if (bus_addr == gpl_pkg::ADDR_PIN_CFG) begin
        s_d.cfg = (s_q.cfg & ~bus_bit_mask[3:0])
                | (bus_wdata[3:0] & bus_bit_mask[3:0]);
        s_d.wait_pend = 1'b1; // [R17]
      end
    end

    // pin drive and pull-up, registered so outputs are clean
    for (int p = 0; p < NP; p++) begin
      s_d.pout[p] = s_q.data[p] & gpl_pkg::PIN_MASK[p]; // [R1] [R3]
      s_d.poe[p]  = ~s_q.dir[p] & gpl_pkg::PIN_MASK[p]; // [R21] [R2]
      s_d.ppu[p]  = s_q.pu[p] & s_q.dir[p] & ~alt_out_en[p*8 +: 8]
                  & gpl_pkg::PU_MASK[p]; // [R11] [R12]
    end
    // analog pins never drive even if software misconfigures
    s_d.poe[gpl_pkg::IDX_P2] = s_d.poe[gpl_pkg::IDX_P2] & dmask; // [R15]
    s_d.ana = ~dmask; // [R15]
  end

  // single state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NP; p++) begin
        s_q.data[p]  <= gpl_pkg::DATA_RST; // [R4]
        s_q.dir[p]   <= gpl_pkg::DIR_RST; // [R22]
        s_q.pu[p]    <= gpl_pkg::PU_RST; // [R14]
        s_q.sync1[p] <= 8'h00;
        s_q.sync2[p] <= 8'h00;
        s_q.pout[p]  <= 8'h00;
        s_q.poe[p]   <= 8'h00;
        s_q.ppu[p]   <= 8'h00;
      end
      s_q.cfg       <= gpl_pkg::CFG_RST; // [R16]
      s_q.rdata     <= 8'h00;
      s_q.wait_pend <= 1'b0;
      s_q.ana       <= 8'hFF; // [R16]
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata           = s_q.rdata;
  assign bus_wait            = s_q.wait_pend;
  assign pin_out             = s_q.pout;
  assign pin_oe              = s_q.poe;
  assign pin_pullup_en       = s_q.ppu;
  assign analog_channel_pins = s_q.ana;

endmodule
`default_nettype wire

// [rtl/gpl_pkg.sv]
package gpl_pkg;
  // register byte addresses on the internal memory bus
  localparam logic [15:0] ADDR_PORT0_DATA  = 16'hFF00;
  localparam logic [15:0] ADDR_PORT1_DATA  = 16'hFF01;
  localparam logic [15:0] ADDR_PORT2_DATA  = 16'hFF02;
  localparam logic [15:0] ADDR_PORT3_DATA  = 16'hFF03;
  localparam logic [15:0] ADDR_PORT6_DATA  = 16'hFF06;
  localparam logic [15:0] ADDR_PORT7_DATA  = 16'hFF07;
  localparam logic [15:0] ADDR_PORT12_DATA = 16'hFF0C;
  localparam logic [15:0] ADDR_DIR0        = 16'hFF20;
  localparam logic [15:0] ADDR_DIR1        = 16'hFF21;
  localparam logic [15:0] ADDR_DIR2        = 16'hFF22;
  localparam logic [15:0] ADDR_DIR3        = 16'hFF23;
  localparam logic [15:0] ADDR_DIR6        = 16'hFF26;
  localparam logic [15:0] ADDR_DIR7        = 16'hFF27;
  localparam logic [15:0] ADDR_DIR12       = 16'hFF2C;
  localparam logic [15:0] ADDR_PIN_CFG     = 16'hFF2F;
  localparam logic [15:0] ADDR_PU0         = 16'hFF30;
  localparam logic [15:0] ADDR_PU1         = 16'hFF31;
  localparam logic [15:0] ADDR_PU3         = 16'hFF33;
  localparam logic [15:0] ADDR_PU7         = 16'hFF37;
  localparam logic [15:0] ADDR_PULLUP_SEL_PORT12        = 16'hFF3C;

  // number of ports and their index in the per-port arrays
  localparam int NPORT = 7;
  localparam logic [2:0] IDX_P0  = 3'h0;
  localparam logic [2:0] IDX_P1  = 3'h1;
  localparam logic [2:0] IDX_P2  = 3'h2;
  localparam logic [2:0] IDX_P3  = 3'h3;
  localparam logic [2:0] IDX_P6  = 3'h4;
  localparam logic [2:0] IDX_P7  = 3'h5;
  localparam logic [2:0] IDX_P12 = 3'h6;

  // implemented pin bits of each port
  localparam logic [7:0] PIN_MASK [NPORT] =
    '{8'h7F, 8'hFF, 8'hFF, 8'h0F, 8'h03, 8'hFF, 8'h1F};
  // implemented pull-up select bits of each port
  localparam logic [7:0] PU_MASK [NPORT] =
    '{8'h7F, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'hFF, 8'h01};

  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'hFF;
  localparam logic [7:0] PU_RST   = 8'h00;
  localparam logic [3:0] CFG_RST  = 4'h0;

  // pin config field and its legal limit
  localparam int         CFG_W   = 4;
  localparam logic [3:0] CFG_MAX = 4'h8;

  // port 12 clock-capable pins
  localparam logic [7:0] P12_CLK_MASK = 8'h1E;
endpackage

// [dv/gpl_board.sv]
`timescale 1ns/100ps
`default_nettype none
module gpl_board (
  input  wire logic [55:0] pin_out,
  input  wire logic [55:0] pin_oe,
  input  wire logic [55:0] pin_pullup_en,
  input  wire logic [55:0] ext_level,
  output logic      [55:0] pin_in
);
  // chip drive wins, then pull-up, else board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup_en)
                | (~pin_oe & ~pin_pullup_en & ext_level);
endmodule
`default_nettype wire

// [dv/gpl_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module gpl_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        bus_sel,
  input wire logic        bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_bit_mask,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_wait,
  input wire logic [55:0] pin_oe,
  input wire logic [55:0] pin_pullup_en,
  input wire logic [7:0]  analog_channel_pins
);
  // pull-up capable bits, one byte per port index
  localparam logic [55:0] PU_BITS = 56'h01FF000F00FF7F;
  logic wr_cfg;
  logic rd_any;
  assign wr_cfg = bus_sel && bus_wr && bus_addr == 16'hFF2F;
  assign rd_any = bus_sel && !bus_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_cfg_wait_pulse: assert property (wr_cfg |=> bus_wait)
    else $error("no wait after pin config write");
  a_wait_has_cause: assert property (bus_wait |-> $past(wr_cfg))
    else $error("wait without pin config write");
  a_rdata_idle_zero: assert property (!$past(rd_any) |-> bus_rdata == 8'h00)
    else $error("read data outside a read");
  a_cfg_high_zero: assert property (
    rd_any && bus_addr == 16'hFF2F |=> bus_rdata[7:4] == 4'h0)
    else $error("pin config upper bits not zero");
  a_pullup_sel_port12_bits_zero: assert property (
    rd_any && bus_addr == 16'hFF3C |=> bus_rdata[7:1] == 7'h00)
    else $error("port12 pull-up upper bits not zero");
  a_pu_mask_only: assert property ((pin_pullup_en & ~PU_BITS) == 56'h0)
    else $error("pull-up on a bit without select");
  a_pu_not_output: assert property ((pin_pullup_en & pin_oe) == 56'h0)
    else $error("pull-up on a driving pin");
  a_analog_no_oe: assert property (
    (pin_oe[23:16] & analog_channel_pins) == 8'h00)
    else $error("analog pin is driven");
  a_cfg_decode_ok: assert property (
    wr_cfg && bus_bit_mask == 8'hFF && bus_wdata <= 8'h08 |=> ##1
    analog_channel_pins == ~((8'h01 << $past(bus_wdata[3:0], 2)) - 8'h01))
    else $error("analog map wrong after config write");
  a_dir_drives_oe: assert property (
    bus_sel && bus_wr && bus_addr == 16'hFF20 && bus_bit_mask == 8'hFF |=> ##1
    pin_oe[7:0] == (~$past(bus_wdata, 2) & 8'h7F))
    else $error("port0 enable does not follow direction");
  // main scenarios reached
  c_cfg_write: cover property (wr_cfg ##1 bus_wait);
  c_pullup_on: cover property (|pin_pullup_en);
  c_port2_digital: cover property (analog_channel_pins == 8'h00);
endmodule
bind gpl_port gpl_checker u_chk (.clk(clk), .resetn(resetn),
  .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_bit_mask(bus_bit_mask),
  .bus_rdata(bus_rdata), .bus_wait(bus_wait), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .analog_channel_pins(analog_channel_pins));
`default_nettype wire

// [dv/gpl_port_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module gpl_port_tb;
  logic        clk = 0;
  logic        resetn = 0;
  logic        bus_sel = 0;
  logic        bus_wr = 0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic [7:0]  bus_bit_mask = 8'hFF;
  logic [7:0]  bus_rdata;
  logic        bus_wait;
  logic [55:0] pin_in;
  logic [55:0] pin_out;
  logic [55:0] pin_oe;
  logic [55:0] pin_pu;
  logic [55:0] alt_out_en = 56'h0;
  logic [55:0] ext_level = 56'h0;
  logic [7:0]  ext_clk = 8'h00;
  logic [7:0]  analog;
  logic        wait_seen = 1'b0;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // data, pull-up and config registers plus one unmapped hole
  localparam logic [15:0] ZERO_REGS [14] = '{16'hFF00, 16'hFF01, 16'hFF02,
    16'hFF03, 16'hFF06, 16'hFF07, 16'hFF0C, 16'hFF2F, 16'hFF30, 16'hFF31,
    16'hFF33, 16'hFF37, 16'hFF3C, 16'hFF04};
  always #4 clk = ~clk;
  gpl_port uut (.clk(clk), .resetn(resetn), .bus_sel(bus_sel),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_bit_mask(bus_bit_mask), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .alt_out_en(alt_out_en),
    .p12_ext_clk_mode(ext_clk), .analog_channel_pins(analog));
  gpl_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu),
    .ext_level(ext_level), .pin_in(pin_in));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [55:0] seen,
                     input logic [55:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one write, request held until the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] m = 8'hFF);
    bus_sel = 1;
    bus_wr = 1;
    bus_addr = a;
    bus_wdata = d;
    bus_bit_mask = m;
    tick(1);
    bus_sel = 0;
    wait_seen = bus_wait;
    tick(1);
  endtask
  // read data stands only in the cycle after the taking edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus_sel = 1;
    bus_wr = 0;
    bus_addr = a;
    tick(1);
    bus_sel = 0;
    chk("bus_rdata", bus_rdata, e);
    tick(1);
  endtask
  task automatic t_reset();
    foreach (ZERO_REGS[i]) rd(ZERO_REGS[i], 8'h00);
    rd(16'hFF20, 8'hFF);
    chk("pin_oe", pin_oe, 56'h0);
    chk("pin_out", pin_out, 56'h0);
    chk("analog", analog, 8'hFF);
  endtask
  task automatic t_output();
    wr(16'hFF20, 8'h00);
    wr(16'hFF00, 8'h55);
    chk("bus_wait", wait_seen, 1'b0);
    tick(1);
    chk("pin_oe", pin_oe[7:0], 8'h7F);
    chk("pin_out", pin_out[7:0], 8'h55);
    rd(16'hFF00, 8'h55);
    rd(16'hFF00, 8'h55);
  endtask
  task automatic t_input();
    ext_level[15:8] = 8'h3C;
    wr(16'hFF01, 8'hA5);
    tick(1);
    chk("pin_oe", pin_oe[15:8], 8'h00);
    rd(16'hFF01, 8'h3C);
    ext_level[15:8] = 8'hC3;
    rd(16'hFF01, 8'h3C);
    tick(2);
    rd(16'hFF01, 8'hC3);
    wr(16'hFF21, 8'h00);
    tick(1);
    chk("pin_out", pin_out[15:8], 8'hA5);
  endtask
  task automatic t_bitop();
    ext_level[47:40] = 8'hFF;
    wr(16'hFF27, 8'hFE);
    wr(16'hFF07, 8'h01, 8'h01);
    rd(16'hFF07, 8'hFF);
    wr(16'hFF27, 8'h00);
    tick(1);
    chk("pin_out", pin_out[47:40], 8'hFF);
    wr(16'hFF07, 8'h00, 8'h08);
    tick(1);
    chk("pin_out", pin_out[47:40], 8'hF7);
  endtask
  task automatic t_pullup();
    wr(16'hFF31, 8'hFF);
    tick(1);
    chk("pullup", pin_pu[15:8], 8'h00);
    wr(16'hFF21, 8'h0F);
    tick(1);
    chk("pullup", pin_pu[15:8], 8'h0F);
    alt_out_en[8] = 1'b1;
    tick(2);
    chk("pullup", pin_pu[15:8], 8'h0E);
    wr(16'hFF33, 8'hFF);
    rd(16'hFF33, 8'h0F);
    wr(16'hFF31, 8'h00);
    tick(1);
    chk("pullup", pin_pu[15:8], 8'h00);
  endtask
  // port2 stays input while analog, as software must keep it
  task automatic t_cfg();
    logic [7:0] e;
    for (int k = 0; k <= 8; k++) begin
      e = ~((8'h01 << k) - 8'h01);
      wr(16'hFF2F, 8'(k)); // peripheral clock always runs here
      chk("bus_wait", wait_seen, 1'b1);
      chk("bus_wait", bus_wait, 1'b0);
      tick(1);
      chk("analog", analog, e);
    end
    wr(16'hFF2F, 8'h00, 8'h08);
    tick(1);
    chk("analog", analog, 8'hFF);
  endtask
  task automatic t_clkpin();
    wr(16'hFF2C, 8'h00);
    wr(16'hFF0C, 8'h1F);
    ext_clk = 8'h1E;
    rd(16'hFF0C, 8'h01);
    ext_clk = 8'h00;
    rd(16'hFF0C, 8'h1F);
  endtask
  // reset in mid-run clears latches and modes at once
  task automatic t_midreset();
    resetn = 0;
    tick(1);
    chk("pin_out", pin_out, 56'h0);
    chk("pin_oe", pin_oe, 56'h0);
    chk("analog", analog, 8'hFF);
    resetn = 1;
    rd(16'hFF2C, 8'hFF);
    chk("pin_out", pin_out, 56'h0);
  endtask
  initial begin
    tick(3);
    resetn = 1;
    t_reset();
    t_output();
    t_input();
    t_bitop();
    t_pullup();
    t_cfg();
    t_clkpin();
    t_midreset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
